// file: src/amic_ctrl.sv
`timescale 1ns/1ps
// Functional notes
// RULE1: one control/status word chooses interrupt sources, shows causes and acknowledges them.
// RULE2: bit 23 reads as the OR of the self-test flag and both mailbox flags and is read only.
// RULE3: the self-test flag in bit 20 sets when the host starts a self test.
// RULE4: the self-test flag stays set until software writes a 1 to bit 20.
// RULE5: add-on logic returns self-test completion codes through the reset control register.
// RULE6: the outgoing mailbox flag in bit 17 can set when the host reads the outgoing mailbox.
// RULE7: the incoming mailbox flag in bit 16 can set when the host writes the incoming mailbox.
// RULE8: writing 1 to bit 17 or 16 clears that flag, writing 0 leaves it alone.
// RULE9: bit 12 enables the outgoing mailbox read interrupt and is read/write.
// RULE10: bits 9:8 pick the outgoing byte that triggers, 00 to 11 meaning byte 0 to byte 3.
// RULE11: bit 4 enables the incoming mailbox write interrupt and is read/write.
// RULE12: bits 1:0 pick the incoming byte that triggers, 00 byte 0 and 11 byte 3.
// RULE13: incoming select codes 01 and 10 pick byte 1 and byte 2.
// RULE14: a mailbox flag sets only when its enable is 1 and the access touches the chosen byte.
module amic_ctrl
    import amic_pkg::*;
#(
    parameter int ADDR_W = AMIC_ADDR_W
)
(
    // clock and reset
    input  wire logic          core_clk,
    input  wire logic          reset_n,
    // add-on register port
    input  wire amic_bus_req_t addon_req,
    output logic [31:0]        addon_rdata,
    output logic               addon_rvalid,
    // host side events
    input  wire amic_pci_evt_t pci_evt,
    // interrupt to add-on logic
    output logic               addon_irq
);

    // ************************************************************
    // elaboration checks
    // ************************************************************
    if (ADDR_W != AMIC_ADDR_W)
    begin : g_bad_addr_w
        $error("amic_ctrl: address width must match the register map");
    end

    // byte lanes are indexed into a four-bit enable
    if (AMIC_LANE_IMB > 3 || AMIC_LANE_OMB > 3 || AMIC_LANE_FLAG > 3)
    begin : g_bad_lane
        $error("amic_ctrl: byte lane outside the word");
    end

    // each writable field must sit in the byte lane that gates its write
    if ((AMIC_BIT_IMB_EN / 8) != AMIC_LANE_IMB)
    begin : g_bad_imb_en_lane
        $error("amic_ctrl: incoming enable outside its byte lane");
    end

    if ((AMIC_IMB_SEL_LSB / 8) != AMIC_LANE_IMB ||
        ((AMIC_IMB_SEL_LSB + 1) / 8) != AMIC_LANE_IMB)
    begin : g_bad_imb_sel_lane
        $error("amic_ctrl: incoming byte select outside its byte lane");
    end

    if ((AMIC_BIT_OMB_EN / 8) != AMIC_LANE_OMB)
    begin : g_bad_omb_en_lane
        $error("amic_ctrl: outgoing enable outside its byte lane");
    end

    if ((AMIC_OMB_SEL_LSB / 8) != AMIC_LANE_OMB ||
        ((AMIC_OMB_SEL_LSB + 1) / 8) != AMIC_LANE_OMB)
    begin : g_bad_omb_sel_lane
        $error("amic_ctrl: outgoing byte select outside its byte lane");
    end

    // the write-one-to-clear flags share one byte lane
    if ((AMIC_BIT_IMB_FLAG / 8) != AMIC_LANE_FLAG)
    begin : g_bad_imb_flag_lane
        $error("amic_ctrl: incoming flag outside the flag lane");
    end

    if ((AMIC_BIT_OMB_FLAG / 8) != AMIC_LANE_FLAG)
    begin : g_bad_omb_flag_lane
        $error("amic_ctrl: outgoing flag outside the flag lane");
    end

    if ((AMIC_BIT_BIST / 8) != AMIC_LANE_FLAG)
    begin : g_bad_bist_lane
        $error("amic_ctrl: self-test flag outside the flag lane");
    end

    // the sticky cells are indexed by the flag constants
    if (AMIC_FLG_IMB >= AMIC_NFLAGS || AMIC_FLG_OMB >= AMIC_NFLAGS ||
        AMIC_FLG_BIST >= AMIC_NFLAGS)
    begin : g_bad_flag_index
        $error("amic_ctrl: flag index outside the flag vector");
    end

    if (AMIC_FLG_IMB == AMIC_FLG_OMB || AMIC_FLG_IMB == AMIC_FLG_BIST ||
        AMIC_FLG_OMB == AMIC_FLG_BIST)
    begin : g_bad_flag_alias
        $error("amic_ctrl: two sources share one flag");
    end

    // hardwired ones must also be part of the reset value
    if ((AMIC_CSR_RESET & AMIC_CSR_HARDWIRE) != AMIC_CSR_HARDWIRE)
    begin : g_bad_hardwire
        $error("amic_ctrl: hardwired bits missing from the reset value");
    end

    // the summary bit must not alias a flag it summarises
    if (AMIC_BIT_IRQ_ANY == AMIC_BIT_BIST || AMIC_BIT_IRQ_ANY == AMIC_BIT_OMB_FLAG ||
        AMIC_BIT_IRQ_ANY == AMIC_BIT_IMB_FLAG)
    begin : g_bad_summary_bit
        $error("amic_ctrl: summary bit overlaps a flag");
    end

    // a hardwired one would hide the enables
    if (AMIC_CSR_HARDWIRE[AMIC_BIT_IMB_EN] || AMIC_CSR_HARDWIRE[AMIC_BIT_OMB_EN])
    begin : g_bad_enable_bit
        $error("amic_ctrl: an enable bit is hardwired");
    end

    // ************************************************************
    // helpers
    // ************************************************************
    // true when the access touched the byte picked by the select code
    function automatic logic amic_byte_hit(input logic [3:0] be, input logic [1:0] sel);
        amic_byte_hit = be[sel];
    endfunction : amic_byte_hit

    // true when one byte lane of a write to the control word is live
    function automatic logic amic_lane_wr(input logic csr_wr, input logic [3:0] be,
                                          input int lane);
        amic_lane_wr = csr_wr & be[lane];
    endfunction : amic_lane_wr

    // ************************************************************
    // state
    // ************************************************************
    logic                   imb_en_reg;
    logic                   imb_en_next;
    logic [1:0]             imb_sel_reg;
    logic [1:0]             imb_sel_next;
    logic                   omb_en_reg;
    logic                   omb_en_next;
    logic [1:0]             omb_sel_reg;
    logic [1:0]             omb_sel_next;
    logic [31:0]            rdata_reg;
    logic [31:0]            rdata_next;
    logic                   rvalid_reg;
    logic                   rvalid_next;
    logic                   irq_reg;
    logic                   irq_next;

    logic                   csr_hit;
    logic                   csr_wr;
    logic                   csr_rd;
    logic [AMIC_NFLAGS-1:0] flag_set;
    logic [AMIC_NFLAGS-1:0] flag_clr;
    logic [AMIC_NFLAGS-1:0] flag;
    logic [AMIC_NFLAGS-1:0] flag_next;
    logic                   irq_any;
    logic [31:0]            csr_value;

    // ************************************************************
    // address decode
    // ************************************************************
    // the control word is the only register of this block
    assign csr_hit = addon_req.sel && (addon_req.addr == AMIC_CSR_OFFSET);
    assign csr_wr  = csr_hit && addon_req.wr;   // see RULE1
    assign csr_rd  = addon_req.sel && addon_req.rd;

    // ************************************************************
    // control fields
    // ************************************************************
    // byte-enabled writes to the enables and byte selects
    always_comb
    begin
        imb_en_next  = imb_en_reg;
        imb_sel_next = imb_sel_reg;
        omb_en_next  = omb_en_reg;
        omb_sel_next = omb_sel_reg;
        if (amic_lane_wr(csr_wr, addon_req.be, AMIC_LANE_IMB))
        begin
            imb_en_next  = addon_req.wdata[AMIC_BIT_IMB_EN];                      // see RULE11
            imb_sel_next = addon_req.wdata[AMIC_IMB_SEL_LSB +: 2];               // see RULE12
        end
        if (amic_lane_wr(csr_wr, addon_req.be, AMIC_LANE_OMB))
        begin
            omb_en_next  = addon_req.wdata[AMIC_BIT_OMB_EN];                      // see RULE9
            omb_sel_next = addon_req.wdata[AMIC_OMB_SEL_LSB +: 2];               // see RULE10
        end
    end

    // register the control fields
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            imb_en_reg  <= AMIC_CSR_RESET[AMIC_BIT_IMB_EN];
            imb_sel_reg <= AMIC_CSR_RESET[AMIC_IMB_SEL_LSB +: 2];
            omb_en_reg  <= AMIC_CSR_RESET[AMIC_BIT_OMB_EN];
            omb_sel_reg <= AMIC_CSR_RESET[AMIC_OMB_SEL_LSB +: 2];
        end
        else
        begin
            imb_en_reg  <= imb_en_next;
            imb_sel_reg <= imb_sel_next;
            omb_en_reg  <= omb_en_next;
            omb_sel_reg <= omb_sel_next;
        end
    end

    // ************************************************************
    // interrupt sources
    // ************************************************************
    // incoming flag: enabled write touching the selected byte, code maps 1:1 to lane
    assign flag_set[AMIC_FLG_IMB] = imb_en_reg &&
        amic_byte_hit(pci_evt.imb_wr_be, imb_sel_reg);   // see RULE7 see RULE13 see RULE14

    // outgoing flag: enabled read touching the selected byte
    assign flag_set[AMIC_FLG_OMB] = omb_en_reg &&
        amic_byte_hit(pci_evt.omb_rd_be, omb_sel_reg);   // see RULE6 see RULE14

    // self-test start always raises its flag
    assign flag_set[AMIC_FLG_BIST] = pci_evt.bist_start;   // see RULE3

    // write-one clears, lane 2 carries all three flags
    assign flag_clr[AMIC_FLG_IMB] = amic_lane_wr(csr_wr, addon_req.be, AMIC_LANE_FLAG) &&
        addon_req.wdata[AMIC_BIT_IMB_FLAG];    // see RULE8
    assign flag_clr[AMIC_FLG_OMB] = amic_lane_wr(csr_wr, addon_req.be, AMIC_LANE_FLAG) &&
        addon_req.wdata[AMIC_BIT_OMB_FLAG];    // see RULE8
    assign flag_clr[AMIC_FLG_BIST] = amic_lane_wr(csr_wr, addon_req.be, AMIC_LANE_FLAG) &&
        addon_req.wdata[AMIC_BIT_BIST];        // see RULE4

    // one sticky cell per source
    for (genvar i = 0; i < AMIC_NFLAGS; i++)
    begin : g_flag
        amic_sticky_flag u_flag
        (
            .core_clk    (core_clk),
            .reset_n     (reset_n),
            .set_pulse   (flag_set[i]),
            .clear_pulse (flag_clr[i]),
            .flag        (flag[i]),
            .flag_next   (flag_next[i])
        );
    end

    // summary of all causes
    assign irq_any = |flag;   // see RULE2

    // ************************************************************
    // read value
    // ************************************************************
    // reserved bits read zero, hardwired bits read one
    always_comb
    begin
        csr_value                        = AMIC_CSR_HARDWIRE;
        csr_value[AMIC_BIT_IRQ_ANY]      = irq_any;                  // see RULE2
        csr_value[AMIC_BIT_BIST]         = flag[AMIC_FLG_BIST];
        csr_value[AMIC_BIT_OMB_FLAG]     = flag[AMIC_FLG_OMB];
        csr_value[AMIC_BIT_IMB_FLAG]     = flag[AMIC_FLG_IMB];
        csr_value[AMIC_BIT_OMB_EN]       = omb_en_reg;
        csr_value[AMIC_OMB_SEL_LSB +: 2] = omb_sel_reg;
        csr_value[AMIC_BIT_IMB_EN]       = imb_en_reg;
        csr_value[AMIC_IMB_SEL_LSB +: 2] = imb_sel_reg;
    end

    // ************************************************************
    // read port and interrupt output
    // ************************************************************
    // read data one cycle after the strobe, other addresses read zero
    always_comb
    begin
        rdata_next  = rdata_reg;
        rvalid_next = csr_rd;
        if (csr_rd)
        begin
            if (csr_hit)
            begin
                rdata_next = csr_value;   // see RULE1
            end
            else
            begin
                rdata_next = 32'h0000_0000;
            end
        end
        irq_next = |flag_next;   // interrupt follows the flags in the same cycle
    end

    // register the outputs
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            rdata_reg  <= 32'h0000_0000;
            rvalid_reg <= 1'b0;
            irq_reg    <= 1'b0;
        end
        else
        begin
            rdata_reg  <= rdata_next;
            rvalid_reg <= rvalid_next;
            irq_reg    <= irq_next;
        end
    end

    assign addon_rdata  = rdata_reg;
    assign addon_rvalid = rvalid_reg;
    assign addon_irq    = irq_reg;

endmodule : amic_ctrl

// file: src/amic_pkg.sv
// ****************************************************************
// constants and carriers for the add-on mailbox interrupt control
// ****************************************************************
package amic_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam int          AMIC_ADDR_W       = 8;
    localparam logic [7:0]  AMIC_CSR_OFFSET   = 8'h38;  // control/status word
    localparam logic [31:0] AMIC_CSR_RESET    = 32'h0000_0c0c;
    localparam logic [31:0] AMIC_CSR_HARDWIRE = 32'h0000_0c0c; // bits 11:10 and 3:2

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int AMIC_BIT_IRQ_ANY  = 23;  // summary, read only
    localparam int AMIC_BIT_BIST     = 20;  // self-test flag
    localparam int AMIC_BIT_OMB_FLAG = 17;  // outgoing mailbox flag
    localparam int AMIC_BIT_IMB_FLAG = 16;  // incoming mailbox flag
    localparam int AMIC_BIT_OMB_EN   = 12;  // outgoing enable
    localparam int AMIC_OMB_SEL_LSB  = 8;   // outgoing byte select 9:8
    localparam int AMIC_BIT_IMB_EN   = 4;   // incoming enable
    localparam int AMIC_IMB_SEL_LSB  = 0;   // incoming byte select 1:0

    // byte lanes that carry each group of fields
    localparam int AMIC_LANE_IMB  = 0;
    localparam int AMIC_LANE_OMB  = 1;
    localparam int AMIC_LANE_FLAG = 2;

    // flag indices inside the flag vector
    localparam int AMIC_NFLAGS   = 3;
    localparam int AMIC_FLG_IMB  = 0;
    localparam int AMIC_FLG_OMB  = 1;
    localparam int AMIC_FLG_BIST = 2;

    // ************************************************************
    // carriers
    // ************************************************************
    // one add-on register access, strobes last one cycle
    typedef struct packed {
        logic                   sel;
        logic                   wr;
        logic                   rd;
        logic [AMIC_ADDR_W-1:0] addr;
        logic [3:0]             be;
        logic [31:0]            wdata;
    } amic_bus_req_t;

    // host-side events, one-cycle pulses on the same clock
    typedef struct packed {
        logic [3:0] imb_wr_be;   // host wrote incoming mailbox, per byte
        logic [3:0] omb_rd_be;   // host read outgoing mailbox, per byte
        logic       bist_start;  // host started a self test
    } amic_pci_evt_t;

endpackage : amic_pkg

// file: src/amic_sticky_flag.sv
`timescale 1ns/1ps
// ****************************************************************
// sticky flag, set by hardware, cleared by write-one
// ****************************************************************
module amic_sticky_flag
(
    // clock and reset
    input  wire logic core_clk,
    input  wire logic reset_n,
    // set and clear
    input  wire logic set_pulse,
    input  wire logic clear_pulse,
    // state
    output logic      flag,
    output logic      flag_next
);

    logic flag_reg;

    // a set in the same cycle as a clear wins
    always_comb
    begin
        flag_next = flag_reg;
        if (clear_pulse)
        begin
            flag_next = 1'b0;
        end
        if (set_pulse)
        begin
            flag_next = 1'b1;
        end
    end

    // register the flag
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            flag_reg <= 1'b0;
        end
        else
        begin
            flag_reg <= flag_next;
        end
    end

    assign flag = flag_reg;

endmodule : amic_sticky_flag

// file: sim/amic_ctrl_properties.sv
`timescale 1ns/1ps
// ****
// port checker for the control/status block
// ****
module amic_ctrl_properties
    import amic_pkg::*;
#(
    parameter int ADDR_W = AMIC_ADDR_W
)
(
    // clock and reset
    input wire logic          core_clk,
    input wire logic          reset_n,
    // add-on register port
    input wire amic_bus_req_t addon_req,
    input wire logic [31:0]   addon_rdata,
    input wire logic          addon_rvalid,
    // host events and interrupt
    input wire amic_pci_evt_t pci_evt,
    input wire logic          addon_irq
);
    logic rd_req;
    logic csr_wr;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);

    // decoded requests
    assign rd_req = addon_req.sel && addon_req.rd;
    assign csr_wr = addon_req.sel && addon_req.wr && addon_req.addr == AMIC_CSR_OFFSET;

    // request steps
    sequence s_csr_read;
        rd_req && addon_req.addr == AMIC_CSR_OFFSET;
    endsequence
    sequence s_clear_all;
        csr_wr && addon_req.be[2] && (&addon_req.wdata[17:16]) && addon_req.wdata[20]
            && pci_evt == '0;
    endsequence

    AST_RVALID_AFTER_READ: assert property (rd_req |=> addon_rvalid)
        else $error("read answer missing");
    AST_RVALID_ONLY_READ: assert property (!rd_req |=> !addon_rvalid)
        else $error("read answer without read");
    AST_FIXED_BITS: assert property (s_csr_read |=> (addon_rdata & 32'hff6c_e0e0) == 32'h0
        && addon_rdata[11:10] == 2'b11 && addon_rdata[3:2] == 2'b11)
        else $error("fixed bits wrong");
    AST_SUMMARY_OR: assert property (s_csr_read |=> addon_rdata[23] ==
        (addon_rdata[20] | addon_rdata[17] | addon_rdata[16]))
        else $error("summary bit not the or of flags");
    AST_SUMMARY_IRQ: assert property (s_csr_read |=> addon_rdata[23] == $past(addon_irq))
        else $error("summary bit differs from interrupt");
    AST_UNMAPPED_ZERO: assert property (rd_req && addon_req.addr != AMIC_CSR_OFFSET
        |=> addon_rdata == 32'h0)
        else $error("unmapped read not zero");
    AST_BIST_RAISES: assert property (pci_evt.bist_start |=> addon_irq)
        else $error("self test did not raise interrupt");
    AST_IRQ_STICKY: assert property (addon_irq && !csr_wr |=> addon_irq)
        else $error("interrupt dropped without write");
    AST_IRQ_CAUSE: assert property ($rose(addon_irq) |->
        $past(|{pci_evt.imb_wr_be, pci_evt.omb_rd_be, pci_evt.bist_start}))
        else $error("interrupt rose without event");
    AST_CLEAR_ALL: assert property (s_clear_all |=> !addon_irq)
        else $error("clear of all flags left interrupt");
endmodule : amic_ctrl_properties

bind amic_ctrl amic_ctrl_properties #(.ADDR_W(ADDR_W)) i_props (.core_clk(core_clk),
    .reset_n(reset_n), .addon_req(addon_req), .addon_rdata(addon_rdata),
    .addon_rvalid(addon_rvalid), .pci_evt(pci_evt), .addon_irq(addon_irq));

// file: sim/amic_addon_model.sv
`timescale 1ns/1ps
// ****
// add-on logic issuing register accesses
// ****
module amic_addon_model
    import amic_pkg::*;
(
    // clock
    input  wire logic    core_clk,
    // register port
    output amic_bus_req_t    addon_req,
    input  wire logic [31:0] addon_rdata,
    input  wire logic        addon_rvalid
);
    // self-test completion codes go through the reset control register, not here
    initial addon_req = '0;

    // one write, taken at the next edge
    task bus_write(input logic [7:0] addr, input logic [3:0] be, input logic [31:0] data);
        @(posedge core_clk);
        #1 addon_req = '{1'b1, 1'b1, 1'b0, addr, be, data};
        @(posedge core_clk);
        #1 addon_req = '0;
    endtask : bus_write

    // one read, answer taken in the cycle after the request
    task bus_read(input logic [7:0] addr, output logic [31:0] data, output logic ok);
        @(posedge core_clk);
        #1 addon_req = '{1'b1, 1'b0, 1'b1, addr, 4'hf, 32'h0};
        @(posedge core_clk);
        #1 ok = addon_rvalid;
        data = addon_rdata;
        addon_req = '0;
    endtask : bus_read
endmodule : amic_addon_model

// file: sim/testbench.sv
`timescale 1ns/1ps
// ****
// testbench for the control/status block
// ****
module testbench
    import amic_pkg::*;
();
    logic          core_clk;
    logic          reset_n;
    amic_bus_req_t addon_req;
    logic [31:0]   addon_rdata;
    logic          addon_rvalid;
    amic_pci_evt_t pci_evt;
    logic          addon_irq;
    logic [31:0]   rd_data;
    logic          rd_ok;
    logic [31:0]   base;
    int            num_errors;
    int            cmp_count;

    amic_ctrl i_dut (.core_clk(core_clk), .reset_n(reset_n), .addon_req(addon_req),
        .addon_rdata(addon_rdata), .addon_rvalid(addon_rvalid), .pci_evt(pci_evt),
        .addon_irq(addon_irq));
    amic_addon_model i_addon (.core_clk(core_clk), .addon_req(addon_req),
        .addon_rdata(addon_rdata), .addon_rvalid(addon_rvalid));

    // clock
    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // compare and count
    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // read and compare
    task rd_chk(input logic [7:0] addr, input logic [31:0] exp);
        i_addon.bus_read(addr, rd_data, rd_ok);
        chk("rvalid", 32'h1, {31'h0, rd_ok});
        chk("rdata", exp, rd_data);
    endtask : rd_chk

    // one host event pulse
    task evt(input logic [3:0] imb, input logic [3:0] omb, input logic bist);
        @(posedge core_clk);
        #1 pci_evt = '{imb, omb, bist};
        @(posedge core_clk);
        #1 pci_evt = '0;
    endtask : evt

    // verdict
    task stop_test();
        if (num_errors == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : stop_test

    // watchdog
    initial
    begin
        #200000;
        num_errors++;
        stop_test();
    end

    // tests
    initial
    begin
        num_errors = 0;
        cmp_count = 0;
        pci_evt = '0;
        reset_n = 1'b0;
        repeat (8) @(posedge core_clk);
        #1 reset_n = 1'b1;
        rd_chk(8'h38, AMIC_CSR_RESET);
        i_addon.bus_write(8'h3c, 4'hf, 32'hffff_ffff);
        rd_chk(8'h3c, 32'h0);
        rd_chk(8'h38, AMIC_CSR_RESET);
        i_addon.bus_write(8'h38, 4'hf, 32'hffff_ffff);
        rd_chk(8'h38, 32'h0000_1f1f);
        for (int n = 0; n < 4; n++)
        begin
            base = 32'h0000_1c1c | (n << 8) | n;
            i_addon.bus_write(8'h38, 4'hf, base | 32'h0013_0000);
            evt(4'h1 << ((n + 1) % 4), 4'h1 << ((n + 3) % 4), 1'b0);
            chk("irq", 32'h0, {31'h0, addon_irq});
            evt(4'h1 << n, 4'h0, 1'b0);
            chk("irq", 32'h1, {31'h0, addon_irq});
            evt(4'h0, 4'h1 << n, 1'b0);
            rd_chk(8'h38, base | 32'h0083_0000);
            i_addon.bus_write(8'h38, 4'h4, 32'h0001_0000);
            rd_chk(8'h38, base | 32'h0082_0000);
            i_addon.bus_write(8'h38, 4'h4, 32'h0002_0000);
            rd_chk(8'h38, base);
        end
        i_addon.bus_write(8'h38, 4'h3, 32'h0);
        evt(4'hf, 4'hf, 1'b0);
        rd_chk(8'h38, 32'h0000_0c0c);
        fork
            evt(4'h0, 4'h0, 1'b1);
            i_addon.bus_write(8'h38, 4'h4, 32'h0013_0000);
        join
        rd_chk(8'h38, 32'h0090_0c0c);
        i_addon.bus_write(8'h38, 4'h4, 32'h0010_0000);
        rd_chk(8'h38, 32'h0000_0c0c);
        chk("irq", 32'h0, {31'h0, addon_irq});
        stop_test();
    end
endmodule : testbench
